/* can_status_irq_accept_filter.sv */
// Purpose: Status, read-to-clear flags, acceptance filter and time quantum prescaler of a CAN controller
// Assumes: Protocol engine events arrive as one-cycle pulses on this clock; bus_activity is a raw pin
// Notes:   APB slave answers with pready on the second access cycle
//
// Notes on behaviour
// - While transmit buffer is locked, CPU writes to it are silently dropped.
// - Message arriving with both receive buffers full sets overrun and is dropped.
// - Overrun flag clears only on a write of the clear overrun command.
// - An outgoing frame needs a receive buffer, so transmission may cause overrun.
// - Receive full sets on a new accepted message, clears on release command.
// - On release, a waiting second buffer goes to CPU and full sets again.
// - Interrupt flag register is read only; reading it clears every flag.
// - Bus activity while asleep clears sleep, then sets wake flag.
// - Overrun sets overrun interrupt flag when enabled; read or reset request clears.
// - Error or bus status change sets error flag when enabled; read clears.
// - End of transmission sets transmit flag when released and enabled.
// - Receive flag sets together with receive full when enabled.
// - Only messages passing the filter are signalled to the CPU.
// - Filter compares the eight code bits with identifier bits ten to three.
// - Clear mask bit demands equality; set mask bit is don't-care.
// - Accepted message stored into a free buffer, else overrun signalled.
// - Code, mask and timing registers are reachable only under reset request.
// - Jump width in quanta equals field plus one, one to four.
// - Time quantum divides the clock by prescaler field plus one.
// - Reset request holds the controller in reset; clearing it resumes operation.
// - Release command bit clears itself when a message is received.
`timescale 1ns/1ps
`default_nettype none

module can_status_irq_accept_filter (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        bus_activity,
	input  wire logic        rx_frame_done,
	input  wire logic [7:0]  rx_frame_id,
	input  wire logic        tx_frame_start,
	input  wire logic        tx_frame_done,
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	input  wire logic        error_status,
	input  wire logic        bus_off_status,
	output var  logic        core_reset,
	output var  logic        sleep_mode,
	output var  logic        tx_request,
	output var  logic        tx_abort,
	output var  logic [7:0]  tx_data,
	output var  logic        tq_tick,
	output var  logic [2:0]  sjw_quanta
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Filter match over the eight identifier bits
	function automatic logic filter_pass(input logic [7:0] id, input logic [7:0] code, input logic [7:0] mask);
		filter_pass = &((~(id ^ code)) | mask);
	endfunction

	// Address decode of one register index
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
		hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
	endfunction

	// ----------------------------------------
	// Reset release and pin synchroniser
	// ----------------------------------------
	logic       rst_meta_reg;
	logic       rst_sync_reg;
	logic       act_meta_reg;
	logic       act_sync_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	wire logic srst_n = rst_sync_reg;

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			act_meta_reg <= 1'b0;
			act_sync_reg <= 1'b0;
		end else begin
			act_meta_reg <= bus_activity;
			act_sync_reg <= act_meta_reg;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic        do_access;
	logic        do_write;
	logic        do_read;
	logic [7:0]  wbyte;
	logic        known;
	logic [7:0]  rd_val;

	logic [7:0]  control_reg;
	logic [7:0]  accept_code_reg;
	logic [7:0]  accept_mask_reg;
	logic [7:0]  bit_timing_zero_reg;
	logic [7:0]  irq_flags_reg;
	logic [7:0]  status_view;
	logic [7:0]  rx_id_view;

	wire logic reset_request = control_reg[can_filter_pkg::CTL_RESET_REQ];

	assign do_access = psel && penable && pready;
	assign do_write  = do_access && pwrite;
	assign do_read   = do_access && !pwrite;
	assign wbyte     = pwdata[7:0];

	always_comb begin
		known  = 1'b1;
		rd_val = can_filter_pkg::ZERO_BYTE;
		if (hit(paddr, can_filter_pkg::IDX_COMMAND)) begin
			rd_val = can_filter_pkg::COMMAND_READ;
		end else if (hit(paddr, can_filter_pkg::IDX_CONTROL)) begin
			rd_val = control_reg;
		end else if (hit(paddr, can_filter_pkg::IDX_STATUS)) begin
			rd_val = status_view;
		end else if (hit(paddr, can_filter_pkg::IDX_IRQ_FLAGS)) begin
			rd_val = irq_flags_reg;
		end else if (hit(paddr, can_filter_pkg::IDX_ACCEPT_CODE)) begin
			rd_val = reset_request ? accept_code_reg : can_filter_pkg::ZERO_BYTE;
		end else if (hit(paddr, can_filter_pkg::IDX_ACCEPT_MASK)) begin
			rd_val = reset_request ? accept_mask_reg : can_filter_pkg::ZERO_BYTE;
		end else if (hit(paddr, can_filter_pkg::IDX_BIT_TIMING)) begin
			rd_val = reset_request ? bit_timing_zero_reg : can_filter_pkg::ZERO_BYTE;
		end else if (hit(paddr, can_filter_pkg::IDX_TX_DATA)) begin
			rd_val = tx_data;
		end else if (hit(paddr, can_filter_pkg::IDX_RX_ID)) begin
			rd_val = rx_id_view;
		end else begin
			known = 1'b0;
		end
	end

	// Answer comes on the second access cycle
	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !known;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= {24'h00_0000, rd_val};
			end
		end
	end

	// ----------------------------------------
	// Register write strobes
	// ----------------------------------------
	wire logic wr_command = do_write && hit(paddr, can_filter_pkg::IDX_COMMAND) && !reset_request;
	wire logic wr_control = do_write && hit(paddr, can_filter_pkg::IDX_CONTROL);
	wire logic wr_config  = do_write && reset_request;
	wire logic rd_flags   = do_read && hit(paddr, can_filter_pkg::IDX_IRQ_FLAGS);

	wire logic cmd_tx_req  = wr_command && wbyte[can_filter_pkg::CMD_TX_REQ];
	wire logic cmd_abort   = wr_command && wbyte[can_filter_pkg::CMD_ABORT];
	wire logic cmd_release = wr_command && wbyte[can_filter_pkg::CMD_RELEASE];
	wire logic cmd_clr_ovr = wr_command && wbyte[can_filter_pkg::CMD_CLR_OVR];

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			control_reg <= can_filter_pkg::CONTROL_RESET;
		end else if (wr_control) begin
			control_reg <= {3'b000, wbyte[4:0]};
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			accept_code_reg     <= can_filter_pkg::CONFIG_RESET;
			accept_mask_reg     <= can_filter_pkg::CONFIG_RESET;
			bit_timing_zero_reg <= can_filter_pkg::CONFIG_RESET;
		end else if (wr_config) begin
			if (hit(paddr, can_filter_pkg::IDX_ACCEPT_CODE)) begin
				accept_code_reg <= wbyte;
			end
			if (hit(paddr, can_filter_pkg::IDX_ACCEPT_MASK)) begin
				accept_mask_reg <= wbyte;
			end
			if (hit(paddr, can_filter_pkg::IDX_BIT_TIMING)) begin
				bit_timing_zero_reg <= wbyte;
			end
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			core_reset <= 1'b1;
		end else begin
			core_reset <= reset_request;
		end
	end

	// ----------------------------------------
	// Transmit buffer and status
	// ----------------------------------------
	logic tx_released_reg;
	logic tx_complete_reg;

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			tx_released_reg <= 1'b1;
			tx_complete_reg <= 1'b1;
			tx_request      <= 1'b0;
			tx_abort        <= 1'b0;
		end else begin
			tx_request <= cmd_tx_req && tx_released_reg;
			tx_abort   <= cmd_abort && !tx_released_reg;
			if (reset_request) begin
				tx_released_reg <= 1'b1;
			end else if (tx_frame_done) begin
				tx_released_reg <= 1'b1;
				tx_complete_reg <= 1'b1;
			end else if (cmd_tx_req) begin
				tx_released_reg <= 1'b0;
				tx_complete_reg <= 1'b0;
			end else if (cmd_abort && !tx_active) begin
				tx_released_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			tx_data <= can_filter_pkg::ZERO_BYTE;
		end else if (do_write && hit(paddr, can_filter_pkg::IDX_TX_DATA) && tx_released_reg) begin
			tx_data <= wbyte;
		end
	end

	// ----------------------------------------
	// Double receive buffer
	// ----------------------------------------
	logic [7:0] rx_id_mem [0:1];
	logic [1:0] rx_count_reg;
	logic       rx_head_reg;
	logic       overrun_reg;
	logic       release_cmd_reg;
	logic       accepted;
	logic       store_ok;
	logic       overrun_event;
	logic       new_to_cpu;
	logic [1:0] count_after_rel;
	logic       head_after_rel;

	assign accepted = rx_frame_done && !reset_request
		&& filter_pass(rx_frame_id, accept_code_reg, accept_mask_reg);

	always_comb begin
		count_after_rel = rx_count_reg;
		head_after_rel  = rx_head_reg;
		if (cmd_release && rx_count_reg != 2'd0) begin
			count_after_rel = rx_count_reg - 2'd1;
			head_after_rel  = !rx_head_reg;
		end
	end

	assign store_ok      = accepted && count_after_rel != 2'd2;
	assign overrun_event = !reset_request
		&& ((accepted || tx_frame_start) && count_after_rel == 2'd2);
	assign new_to_cpu    = (store_ok && count_after_rel == 2'd0)
		|| (cmd_release && rx_count_reg == 2'd2);

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			rx_count_reg <= 2'd0;
			rx_head_reg  <= 1'b0;
		end else if (reset_request) begin
			rx_count_reg <= 2'd0;
			rx_head_reg  <= 1'b0;
		end else begin
			rx_head_reg <= head_after_rel;
			if (store_ok) begin
				rx_count_reg <= count_after_rel + 2'd1;
				rx_id_mem[head_after_rel ^ count_after_rel[0]] <= rx_frame_id;
			end else begin
				rx_count_reg <= count_after_rel;
			end
		end
	end

	assign rx_id_view = rx_id_mem[rx_head_reg];

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			overrun_reg <= 1'b0;
		end else if (overrun_event) begin
			overrun_reg <= 1'b1;
		end else if (cmd_clr_ovr) begin
			overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			release_cmd_reg <= 1'b0;
		end else if (store_ok) begin
			release_cmd_reg <= 1'b0;
		end else if (cmd_release) begin
			release_cmd_reg <= 1'b1;
		end
	end

	assign status_view = {bus_off_status, error_status, tx_active, rx_active,
		tx_complete_reg, tx_released_reg, overrun_reg, rx_count_reg != 2'd0};

	// ----------------------------------------
	// Sleep and wake-up
	// ----------------------------------------
	logic wake_pending_reg;

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			sleep_mode       <= 1'b0;
			wake_pending_reg <= 1'b0;
		end else begin
			wake_pending_reg <= sleep_mode && act_sync_reg;
			if (sleep_mode && act_sync_reg) begin
				sleep_mode <= 1'b0;
			end else if (wr_command) begin
				sleep_mode <= wbyte[can_filter_pkg::CMD_SLEEP];
			end
		end
	end

	// ----------------------------------------
	// Interrupt flags, read to clear
	// ----------------------------------------
	logic       err_prev_reg;
	logic       bus_prev_reg;
	logic [4:0] flag_set;
	logic [4:0] flag_bits_reg;

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			err_prev_reg <= 1'b0;
			bus_prev_reg <= 1'b0;
		end else begin
			err_prev_reg <= error_status;
			bus_prev_reg <= bus_off_status;
		end
	end

	always_comb begin
		flag_set = 5'b00000;
		flag_set[can_filter_pkg::IF_RX]   = new_to_cpu && control_reg[can_filter_pkg::CTL_RX_IE];
		flag_set[can_filter_pkg::IF_TX]   = tx_frame_done && control_reg[can_filter_pkg::CTL_TX_IE];
		flag_set[can_filter_pkg::IF_ERR]  = control_reg[can_filter_pkg::CTL_ERR_IE]
			&& ((error_status != err_prev_reg) || (bus_off_status != bus_prev_reg));
		flag_set[can_filter_pkg::IF_OVR]  = overrun_event && control_reg[can_filter_pkg::CTL_OVR_IE];
		flag_set[can_filter_pkg::IF_WAKE] = wake_pending_reg;
	end

	generate
		for (genvar i = 0; i < 5; i++) begin : g_flag
			localparam bit RR_CLEARS = (i != can_filter_pkg::IF_ERR) && (i != can_filter_pkg::IF_WAKE);
			always_ff @(posedge clock or negedge srst_n) begin
				if (!srst_n) begin
					flag_bits_reg[i] <= 1'b0;
				end else if (flag_set[i]) begin
					flag_bits_reg[i] <= 1'b1;
				end else if (rd_flags || (RR_CLEARS && reset_request)) begin
					flag_bits_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq_flags_reg = {3'b000, flag_bits_reg};

	// ----------------------------------------
	// Time quantum prescaler and jump width
	// ----------------------------------------
	logic [5:0] presc_cnt_reg;
	wire  logic [5:0] presc_field = bit_timing_zero_reg[can_filter_pkg::BT_PRESC_LSB +: can_filter_pkg::BT_PRESC_W];
	wire  logic [1:0] sjw_field   = bit_timing_zero_reg[can_filter_pkg::BT_SJW_LSB +: can_filter_pkg::BT_SJW_W];

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			presc_cnt_reg <= 6'd0;
			tq_tick       <= 1'b0;
		end else if (reset_request) begin
			presc_cnt_reg <= 6'd0;
			tq_tick       <= 1'b0;
		end else if (presc_cnt_reg >= presc_field) begin
			presc_cnt_reg <= 6'd0;
			tq_tick       <= 1'b1;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + 6'd1;
			tq_tick       <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			sjw_quanta <= 3'd1;
		end else begin
			sjw_quanta <= {1'b0, sjw_field} + 3'd1;
		end
	end

endmodule

`default_nettype wire

/* can_filter_pkg.sv */
// Purpose: Shared constants for the CAN status, flag, filter and prescaler block
// Assumes: Registers are 8 bits wide, each in one aligned 32-bit APB word
// Notes:   Byte address of a register is four times its index
package can_filter_pkg;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [7:0] IDX_COMMAND     = 8'h20;
	localparam logic [7:0] IDX_CONTROL     = 8'h21;
	localparam logic [7:0] IDX_STATUS      = 8'h22;
	localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h23;
	localparam logic [7:0] IDX_ACCEPT_CODE = 8'h24;
	localparam logic [7:0] IDX_ACCEPT_MASK = 8'h25;
	localparam logic [7:0] IDX_BIT_TIMING  = 8'h26;
	localparam logic [7:0] IDX_TX_DATA     = 8'h2A;
	localparam logic [7:0] IDX_RX_ID       = 8'h2B;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_RESET_REQ = 0;
	localparam int CTL_RX_IE     = 1;
	localparam int CTL_TX_IE     = 2;
	localparam int CTL_ERR_IE    = 3;
	localparam int CTL_OVR_IE    = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h01;

	// ----------------------------------------
	// Command register fields
	// ----------------------------------------
	localparam int CMD_TX_REQ    = 0;
	localparam int CMD_ABORT     = 1;
	localparam int CMD_RELEASE   = 2;
	localparam int CMD_CLR_OVR   = 3;
	localparam int CMD_SLEEP     = 4;
	localparam logic [7:0] COMMAND_READ = 8'hFF;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int ST_RX_FULL  = 0;
	localparam int ST_OVERRUN  = 1;
	localparam int ST_TX_REL   = 2;
	localparam int ST_TX_DONE  = 3;
	localparam int ST_RX_ACT   = 4;
	localparam int ST_TX_ACT   = 5;
	localparam int ST_ERR      = 6;
	localparam int ST_BUS_OFF  = 7;

	// ----------------------------------------
	// Interrupt flag register fields
	// ----------------------------------------
	localparam int IF_RX   = 0;
	localparam int IF_TX   = 1;
	localparam int IF_ERR  = 2;
	localparam int IF_OVR  = 3;
	localparam int IF_WAKE = 4;

	// ----------------------------------------
	// Bit timing fields and reset values
	// ----------------------------------------
	localparam int BT_PRESC_LSB = 0;
	localparam int BT_PRESC_W   = 6;
	localparam int BT_SJW_LSB   = 6;
	localparam int BT_SJW_W     = 2;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE    = 8'h00;

endpackage

/* can_filter_props.sv */
// Purpose: Port checker for the CAN status, flag and filter block
// Assumes: APB byte address is four times the register index
// Notes:   Bound to the design top below
`timescale 1ns/1ps
`default_nettype none
module can_filter_props (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        bus_activity,
	input wire logic        tx_frame_done,
	input wire logic        core_reset,
	input wire logic        sleep_mode,
	input wire logic        tx_request,
	input wire logic        tx_abort,
	input wire logic [7:0]  tx_data,
	input wire logic        tq_tick,
	input wire logic [2:0]  sjw_quanta
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic       xfer;
	logic       bt_wr;
	logic       locked;
	logic       tvalid;
	logic [7:0] bt_v;
	logic [6:0] gap;
	assign xfer  = psel && penable && pready;
	assign bt_wr = xfer && pwrite && paddr == 8'h98 && core_reset;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bt_v   <= 8'h00;
			locked <= 1'b0;
			tvalid <= 1'b0;
			gap    <= 7'h00;
		end else begin
			if (bt_wr)
				bt_v <= pwdata[7:0];
			if (tx_request)
				locked <= 1'b1;
			else if (tx_frame_done || tx_abort || core_reset)
				locked <= 1'b0;
			gap <= tq_tick ? 7'h00 : gap + 7'h01;
			if (core_reset)
				tvalid <= 1'b0;
			else if (tq_tick)
				tvalid <= 1'b1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence acc_start;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence wake_seen;
		sleep_mode && bus_activity;
	endsequence
	a_ready_one_wait: assert property (acc_start |-> !pready ##1 pready) else $error("pready wait wrong");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_unmapped_err: assert property (xfer |-> pslverr == !(paddr inside {8'h80, 8'h84, 8'h88, 8'h8C, 8'h90,
		8'h94, 8'h98, 8'hA8, 8'hAC})) else $error("pslverr wrong");
	a_cfg_hidden: assert property (xfer && !pwrite && !core_reset && paddr inside {8'h90, 8'h94, 8'h98}
		|-> prdata == 32'h0) else $error("config readable out of reset");
	a_jump_width: assert property (bt_wr |=> ##[0:2] sjw_quanta == 3'(bt_v[7:6]) + 3'h1)
		else $error("jump width wrong");
	a_tick_gap: assert property (tq_tick && tvalid |-> gap == {1'b0, bt_v[5:0]})
		else $error("quantum period wrong");
	a_reset_holds: assert property (xfer && pwrite && paddr == 8'h80 && core_reset |=> !tx_request [*2])
		else $error("command taken in reset");
	a_sleep_wake: assert property (wake_seen |-> ##[1:5] !sleep_mode) else $error("no wake");
	a_tx_locked: assert property (xfer && pwrite && paddr == 8'hA8 && locked |=> $stable(tx_data) [*2])
		else $error("locked buffer written");
endmodule
bind can_status_irq_accept_filter can_filter_props can_filter_props_i (.*);
`default_nettype wire

/* can_node_model.sv */
// Purpose: Far side of the block: engine events from other bus nodes
// Assumes: Events are driven just after a rising clock edge
// Notes:   Identifier lines show the inverse of the last value when idle
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
	input  wire logic       clock,
	input  wire logic       tx_request,
	output var  logic       rx_frame_done,
	output var  logic [7:0] rx_frame_id,
	output var  logic       tx_frame_start,
	output var  logic       tx_frame_done,
	output var  logic       tx_active,
	output var  logic       rx_active,
	output var  logic       error_status,
	output var  logic       bus_off_status,
	output var  logic       bus_activity
);
	initial begin
		{rx_frame_done, tx_frame_start, tx_frame_done, tx_active} = 4'h0;
		{rx_active, error_status, bus_off_status, bus_activity} = 4'h0;
		rx_frame_id = 8'h5A;
	end
	task rx(input logic [7:0] id);
		@(posedge clock) rx_active <= 1'b1;
		repeat (4) @(posedge clock);
		rx_frame_done <= 1'b1;
		rx_frame_id <= id;
		rx_active <= 1'b0;
		@(posedge clock) rx_frame_done <= 1'b0;
		rx_frame_id <= ~id;
	endtask
	task set_err(input logic v);
		@(posedge clock) error_status <= v;
	endtask
	task set_off(input logic v);
		@(posedge clock) bus_off_status <= v;
	endtask
	task wake;
		@(posedge clock) bus_activity <= 1'b1;
		repeat (4) @(posedge clock);
		bus_activity <= 1'b0;
	endtask
	// A requested frame wins the bus and takes a long while to send
	initial forever begin
		@(posedge clock);
		if (tx_request === 1'b1) begin
			repeat (2) @(posedge clock);
			tx_frame_start <= 1'b1;
			tx_active <= 1'b1;
			@(posedge clock) tx_frame_start <= 1'b0;
			repeat (40) @(posedge clock);
			tx_active <= 1'b0;
			tx_frame_done <= 1'b1;
			@(posedge clock) tx_frame_done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* test_can_status_irq_accept_filter.sv */
// Purpose: Self-checking bench for the CAN status, flag and filter block
// Assumes: Register byte address is four times its index
// Notes:   Scenarios run in order and share the controller state
`timescale 1ns/1ps
`default_nettype none
module test_can_status_irq_accept_filter;
	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready, pslverr, bus_activity, rx_frame_done, tx_frame_start, tx_frame_done;
	logic        tx_active, rx_active, error_status, bus_off_status, core_reset, sleep_mode;
	logic        tx_request, tx_abort, tq_tick;
	logic [7:0]  rx_frame_id, tx_data, r;
	logic [2:0]  sjw_quanta;
	logic        e;
	int          failures = 0;
	int          n_checks = 0;
	int          cycles = 0;
	can_status_irq_accept_filter can_status_irq_accept_filter_i (.*);
	can_node_model can_node_model_i (.*);
	always #4 clock = ~clock;
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// ----------------------------------------
	// APB master
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clock) penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task rd(input logic [7:0] i);
		apb(1'b0, i, 8'h00);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd(8'h22); check("status", r, 8'h0C);
		rd(8'h21); check("control", r, 8'h01);
		rd(8'h20); check("command", r, 8'hFF);
		wr(8'h20, 8'h01);
		rd(8'h22); check("tx released", r & 8'h04, 8'h04);
		rd(8'h30); check("unmapped", {7'h0, e}, 8'h01);
		wr(8'h23, 8'hFF);
		rd(8'h23); check("irq", r, 8'h00);
	endtask
	task t_config;
		int n;
		wr(8'h26, 8'h7F);
		repeat (2) @(posedge clock);
		check("sjw two", {5'h0, sjw_quanta}, 8'h02);
		wr(8'h24, 8'hC5);
		wr(8'h25, 8'h0F);
		wr(8'h26, 8'hC2);
		rd(8'h24); check("code", r, 8'hC5);
		rd(8'h26); check("timing", r, 8'hC2);
		check("sjw max", {5'h0, sjw_quanta}, 8'h04);
		wr(8'h21, 8'h1E);
		rd(8'h25); check("mask hidden", r, 8'h00);
		do @(posedge clock); while (tq_tick !== 1'b1);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (tq_tick !== 1'b1 && n < 100);
		check("quantum", n[7:0], 8'h03);
	endtask
	task t_rx;
		can_node_model_i.rx(8'hC3);
		rd(8'h22); check("rx full", r & 8'h01, 8'h01);
		rd(8'h23); check("rx irq", r & 8'h01, 8'h01);
		rd(8'h23); check("irq cleared", r, 8'h00);
		can_node_model_i.rx(8'h45);
		can_node_model_i.rx(8'hCC);
		rd(8'h2B); check("rx id", r, 8'hC3);
		wr(8'h20, 8'h04);
		rd(8'h2B); check("second id", r, 8'hCC);
		rd(8'h22); check("full again", r & 8'h01, 8'h01);
		can_node_model_i.rx(8'hC0);
		can_node_model_i.rx(8'hCF);
		rd(8'h22); check("overrun", r & 8'h02, 8'h02);
		rd(8'h23); check("ovr irq", r & 8'h08, 8'h08);
		rd(8'h22); check("overrun held", r & 8'h02, 8'h02);
		wr(8'h20, 8'h08);
		rd(8'h22); check("overrun clear", r & 8'h02, 8'h00);
		wr(8'h20, 8'h04);
		rd(8'h2B); check("third id", r, 8'hC0);
		wr(8'h20, 8'h04);
		rd(8'h22); check("rx empty", r & 8'h01, 8'h00);
	endtask
	task t_tx;
		int n;
		can_node_model_i.rx(8'hC1);
		can_node_model_i.rx(8'hC2);
		rd(8'h23);
		wr(8'h2A, 8'h5A);
		wr(8'h20, 8'h01);
		wr(8'h2A, 8'h77);
		rd(8'h22); check("locked", r & 8'h04, 8'h00);
		check("tx data", tx_data, 8'h5A);
		n = 0;
		do begin
			rd(8'h22);
			n++;
		end while (r[2] !== 1'b1 && n < 40);
		check("released", r & 8'h04, 8'h04);
		check("tx overrun", r & 8'h02, 8'h02);
		rd(8'h23); check("tx irq", r & 8'h02, 8'h02);
		check("tx ovr irq", r & 8'h08, 8'h08);
		rd(8'h2A); check("tx data kept", r, 8'h5A);
	endtask
	task t_err;
		can_node_model_i.set_err(1'b1);
		repeat (3) @(posedge clock);
		rd(8'h23); check("err irq", r & 8'h04, 8'h04);
		rd(8'h23); check("err cleared", r, 8'h00);
		can_node_model_i.set_err(1'b0);
		repeat (3) @(posedge clock);
		rd(8'h23); check("err irq fall", r & 8'h04, 8'h04);
		can_node_model_i.set_off(1'b1);
		repeat (3) @(posedge clock);
		rd(8'h23); check("bus irq", r & 8'h04, 8'h04);
		rd(8'h22); check("bus off", r & 8'h80, 8'h80);
	endtask
	task t_wake;
		wr(8'h20, 8'h10);
		repeat (2) @(posedge clock);
		check("asleep", {7'h0, sleep_mode}, 8'h01);
		can_node_model_i.wake();
		repeat (4) @(posedge clock);
		check("awake", {7'h0, sleep_mode}, 8'h00);
		rd(8'h23); check("wake irq", r & 8'h10, 8'h10);
	endtask
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_config();
		t_rx();
		t_tx();
		t_err();
		t_wake();
		complete_run();
	end
endmodule
`default_nettype wire
